// ==== include/icc_cfg.svh ====
// Offsets, field positions, reset values and timing counts for the common-command block
`ifndef ICC_CFG_SVH
`define ICC_CFG_SVH
`define ICC_SLOTS 99
`define ICC_SLOT_W 7
`define ICC_LVL_W 16
`define ICC_MODE_W 2
`define ICC_STB_OPERATION_SUMMARY_BIT 7
`define ICC_STB_MSS 6
`define ICC_STB_ESB 5
`define ICC_STB_MAV 4
`define ICC_STB_QUESTIONABLE_SUMMARY_BIT 3
`define ICC_STB_ERRQ 2
`define ICC_SRE_RST 8'h00
`define ICC_SRE_WMASK 8'hBF
`define ICC_TST_N 4
`define ICC_OPT_LEN 4
`define ICC_SETTLE_NS 1000
`define ICC_CLK_MHZ 125
`define ICC_SETTLE_CYC ((`ICC_SETTLE_NS * `ICC_CLK_MHZ + 999) / 1000)
`endif

// ==== include/icc_pkg.sv ====
// Types for the common-command block
package icc_pkg;
	typedef enum logic [3:0] {
		ICC_CMD_NONE = 4'h0,
		ICC_CMD_OPT = 4'h1,
		ICC_CMD_RCL = 4'h2,
		ICC_CMD_RST = 4'h3,
		ICC_CMD_SAV = 4'h4,
		ICC_CMD_SRE = 4'h5,
		ICC_CMD_SREQ = 4'h6,
		ICC_CMD_STBQ = 4'h7,
		ICC_CMD_TRG = 4'h8,
		ICC_CMD_TST = 4'h9,
		ICC_CMD_WAI = 4'hA,
		ICC_CMD_GET = 4'hB,
		ICC_CMD_SPOLL = 4'hC
	} icc_cmd_t;
	typedef enum logic [2:0] {
		ICC_ST_IDLE = 3'b000,
		ICC_ST_RD = 3'b001,
		ICC_ST_RCL = 3'b010,
		ICC_ST_TST = 3'b011,
		ICC_ST_OPT = 3'b100,
		ICC_ST_WAIT = 3'b101
	} icc_state_t;
endpackage

// ==== test/icc_chk.sv ====
// Assertion checker for the common-command block
`timescale 1ns/1ps
module icc_chk #(
	parameter int LVL_W = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Commands and replies
	input wire logic cmd_valid,
	input wire icc_pkg::icc_cmd_t cmd_code,
	input wire logic [7:0] cmd_arg,
	input wire logic cmd_ready,
	input wire logic reply_valid,
	input wire logic [7:0] reply_data,
	// Output channel and status
	input wire logic fault_set,
	input wire logic output_on,
	input wire logic [LVL_W-1:0] out_voltage,
	input wire logic [LVL_W-1:0] out_current,
	input wire logic mode_current,
	input wire logic range_auto,
	input wire logic fault_latched,
	input wire logic waiting_for_trigger_flag,
	input wire logic [7:0] service_request_mask
);
	wire logic tk = cmd_valid && cmd_ready;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	mask_bit6_a: assert property (service_request_mask[6] == 1'b0) else $error("mask bit 6 set");
	mask_write_a: assert property (tk && cmd_code == icc_pkg::ICC_CMD_SRE |=>
		service_request_mask == ($past(cmd_arg) & 8'hBF)) else $error("mask write wrong");
	reset_exit_a: assert property ($fell(rst) |-> range_auto && !output_on && !mode_current)
		else $error("reset state wrong");
	reset_cmd_a: assert property (tk && cmd_code == icc_pkg::ICC_CMD_RST |=>
		!output_on && out_voltage == '0 && out_current == '0 && !mode_current && range_auto)
		else $error("reset command effect wrong");
	fault_clear_a: assert property (tk && cmd_code == icc_pkg::ICC_CMD_RST && !fault_set |=>
		!fault_latched) else $error("fault not cleared");
	status_bits_a: assert property (tk && cmd_code inside {icc_pkg::ICC_CMD_STBQ,
		icc_pkg::ICC_CMD_SPOLL} |=> reply_valid && reply_data[1:0] == 2'h0) else $error("status reply wrong");
	mask_query_a: assert property (tk && cmd_code == icc_pkg::ICC_CMD_SREQ |=>
		reply_valid && reply_data == service_request_mask) else $error("mask reply wrong");
	idle_trig_a: assert property (tk && cmd_code inside {icc_pkg::ICC_CMD_TRG,
		icc_pkg::ICC_CMD_GET} && !waiting_for_trigger_flag |=> $stable(out_voltage) && $stable(out_current))
		else $error("unarmed trigger acted");
	opt_burst_a: assert property (tk && cmd_code == icc_pkg::ICC_CMD_OPT |=>
		!reply_valid ##1 reply_valid [*4]) else $error("options reply wrong");
	test_reply_a: assert property (tk && cmd_code == icc_pkg::ICC_CMD_TST |=>
		!reply_valid ##1 reply_valid) else $error("self-test reply late");
endmodule

// ==== test/icc_ctrl_model.sv ====
// Bus controller model: offers commands and collects replies
`timescale 1ns/1ps
module icc_ctrl_model (
	// Clock
	input wire logic ref_clk,
	// Command handshake
	output logic cmd_valid,
	output icc_pkg::icc_cmd_t cmd_code,
	output logic [7:0] cmd_arg,
	input wire logic cmd_ready,
	// Replies and hang flag
	input wire logic reply_valid,
	input wire logic [7:0] reply_data,
	output logic timed_out
);
	logic [7:0] rq[$];
	initial begin
		cmd_valid = 1'b0;
		cmd_code = icc_pkg::ICC_CMD_NONE;
		cmd_arg = 8'h00;
		timed_out = 1'b0;
	end
	// Replies last one cycle, so catch each at its edge
	always @(posedge ref_clk) begin
		if (reply_valid) begin
			rq.push_back(reply_data);
		end
	end
	// Caller keeps slot numbers in 1..99
	task automatic send(input icc_pkg::icc_cmd_t c, input logic [7:0] a);
		int n;
		n = 0;
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_arg = a;
		do begin
			@(posedge ref_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 60);
		if (cmd_ready !== 1'b1) begin
			timed_out = 1'b1;
		end
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		// Released lines show no stale value
		cmd_arg = ~a;
	endtask
endmodule

// ==== test/test_ieee488_common_cmd_status.sv ====
// Self-checking bench for the common-command block
`timescale 1ns/1ps
module test_ieee488_common_cmd_status;
	localparam int LVL_W = 16;
	logic ref_clk, cmd_valid, cmd_ready, reply_valid, output_on, mode_current, range_auto, fault_latched;
	logic rst = 1'b1, listen_addr = 1'b0, continuous_initiation = 1'b0, arm_req = 1'b0, fault_set = 1'b0;
	logic operation_summary_bit = 1'b0, message_available_bit = 1'b0, output_busy = 1'b0;
	logic questionable_summary_bit = 1'b0, error_queue_nonempty_bit = 1'b0;
	logic [7:0] std_event_status = 8'h00, std_event_enable = 8'h00;
	logic [LVL_W-1:0] trigger_voltage_level = 16'h0000, trigger_current_level = 16'h0000;
	logic [1:0] triggered_function_mode = 2'h0;
	logic [3:0] subtest_fail = 4'h0;
	logic [LVL_W-1:0] out_voltage, out_current;
	logic [1:0] out_mode;
	logic [7:0] cmd_arg, reply_data, service_request_mask, r;
	logic waiting_for_trigger_flag, srq_n, timed_out;
	logic [7:0] opt_exp [4] = '{8'h01, 8'h01, 8'h63, 8'hFF};
	icc_pkg::icc_cmd_t cmd_code;
	int err_count = 0;
	int compares = 0;
	// Short settle count keeps the wait scenario brief
	icc_common_cmd #(.SETTLE_CYC(2)) dut (.*);
	icc_ctrl_model ctl (.*);
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic reply(output logic [7:0] d);
		int n;
		n = 0;
		while (ctl.rq.size() == 0 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		if (ctl.rq.size() == 0) begin
			err_count++;
			end_of_test;
		end else begin
			d = ctl.rq.pop_front();
		end
	endtask
	task automatic q(input icc_pkg::icc_cmd_t c, input logic [7:0] a, input logic [7:0] exp);
		ctl.send(c, a);
		reply(r);
		chk(r, exp);
	endtask
	task automatic end_of_test;
		$display("compares %0d, err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge timed_out) begin
		err_count++;
		end_of_test;
	end
	task automatic t_status;
		chk(srq_n, 1'b1);
		ctl.send(icc_pkg::ICC_CMD_SRE, 8'hFF);
		idle(1);
		chk(service_request_mask, 8'hBF);
		q(icc_pkg::ICC_CMD_SREQ, 8'h00, 8'hBF);
		operation_summary_bit = 1'b1;
		message_available_bit = 1'b1;
		questionable_summary_bit = 1'b1;
		error_queue_nonempty_bit = 1'b1;
		std_event_status = 8'h01;
		std_event_enable = 8'h01;
		q(icc_pkg::ICC_CMD_STBQ, 8'h00, 8'hFC);
		chk(srq_n, 1'b0);
		q(icc_pkg::ICC_CMD_STBQ, 8'h00, 8'hFC);
		q(icc_pkg::ICC_CMD_SPOLL, 8'h00, 8'hFC);
		q(icc_pkg::ICC_CMD_STBQ, 8'h00, 8'hFC);
		chk(srq_n, 1'b1);
		q(icc_pkg::ICC_CMD_SPOLL, 8'h00, 8'hBC);
		ctl.send(icc_pkg::ICC_CMD_SRE, 8'h80);
		operation_summary_bit = 1'b0;
		q(icc_pkg::ICC_CMD_STBQ, 8'h00, 8'h3C);
		std_event_enable = 8'h00;
		q(icc_pkg::ICC_CMD_STBQ, 8'h00, 8'h1C);
	endtask
	task automatic t_memory;
		trigger_voltage_level = 16'h1234;
		trigger_current_level = 16'h0567;
		triggered_function_mode = 2'h2;
		ctl.send(icc_pkg::ICC_CMD_SAV, 8'h63);
		trigger_voltage_level = 16'h0ABC;
		trigger_current_level = 16'h0000;
		ctl.send(icc_pkg::ICC_CMD_RCL, 8'h63);
		idle(2);
		chk(out_voltage, 16'h0000);
		ctl.send(icc_pkg::ICC_CMD_RCL, 8'h63);
		idle(2);
		chk(out_voltage, 16'h1234);
		chk(out_current, 16'h0567);
		chk(out_mode, 2'h2);
	endtask
	task automatic t_trigger;
		arm_req = 1'b1;
		idle(1);
		arm_req = 1'b0;
		ctl.send(icc_pkg::ICC_CMD_TRG, 8'h00);
		idle(1);
		chk(out_voltage, 16'h1234);
		listen_addr = 1'b1;
		idle(3);
		ctl.send(icc_pkg::ICC_CMD_TRG, 8'h00);
		idle(1);
		chk(out_voltage, 16'h0ABC);
		chk(waiting_for_trigger_flag, 1'b0);
		trigger_voltage_level = 16'h0DEF;
		ctl.send(icc_pkg::ICC_CMD_TRG, 8'h00);
		idle(1);
		chk(out_voltage, 16'h0ABC);
		continuous_initiation = 1'b1;
		arm_req = 1'b1;
		idle(1);
		arm_req = 1'b0;
		ctl.send(icc_pkg::ICC_CMD_GET, 8'h00);
		idle(1);
		chk(waiting_for_trigger_flag, 1'b1);
		chk(out_voltage, 16'h0DEF);
	endtask
	task automatic t_misc;
		ctl.send(icc_pkg::ICC_CMD_NONE, 8'h01);
		fault_set = 1'b1;
		idle(1);
		fault_set = 1'b0;
		idle(1);
		chk(fault_latched, 1'b1);
		chk(output_on, 1'b1);
		ctl.send(icc_pkg::ICC_CMD_RST, 8'h00);
		idle(1);
		chk(output_on, 1'b0);
		chk(out_voltage, 16'h0000);
		chk(fault_latched, 1'b0);
		chk(range_auto, 1'b1);
		subtest_fail = 4'h5;
		idle(3);
		q(icc_pkg::ICC_CMD_TST, 8'h00, 8'h05);
		ctl.send(icc_pkg::ICC_CMD_OPT, 8'h00);
		foreach (opt_exp[i]) begin
			reply(r);
			chk(r, opt_exp[i]);
		end
		output_busy = 1'b1;
		ctl.send(icc_pkg::ICC_CMD_WAI, 8'h00);
		idle(10);
		chk(cmd_ready, 1'b0);
		output_busy = 1'b0;
		q(icc_pkg::ICC_CMD_SREQ, 8'h00, 8'h80);
	endtask
	task automatic t_reset;
		ctl.send(icc_pkg::ICC_CMD_NONE, 8'h01);
		idle(1);
		chk(output_on, 1'b1);
		rst = 1'b1;
		idle(3);
		rst = 1'b0;
		idle(2);
		chk(output_on, 1'b0);
		chk(range_auto, 1'b1);
		chk(service_request_mask, 8'h00);
		chk(srq_n, 1'b1);
		q(icc_pkg::ICC_CMD_SREQ, 8'h00, 8'h00);
	endtask
	initial begin
		repeat (6) @(negedge ref_clk);
		rst = 1'b0;
		idle(2);
		t_status;
		t_memory;
		t_trigger;
		t_misc;
		t_reset;
		end_of_test;
	end
endmodule
bind icc_common_cmd icc_chk #(.LVL_W(LVL_W)) chk (.*);

// ==== verilog/icc_common_cmd.sv ====
// Common-command interpreter with status byte and service request logic
// Summary of operation
// - Options query returns capability tokens: calibration, remote-on-bus, memory steps, list steps.
// - Recall selects one of 99 slots; controller supplies 1 through 99.
// - First recall loads trigger stage; second recall moves stage to output.
// - Reset turns output off, zeroes voltage and current, selects voltage mode.
// - Reset clears latched overvoltage or overcurrent condition.
// - Every reset returns mode to voltage and range to automatic.
// - Save stores trigger voltage, trigger current and triggered mode to a slot.
// - Service request mask takes 0 to 255; bit 6 not writable.
// - Status bits gated by mask, ORed into status bit 6.
// - Master summary persists on read; request flag cleared by serial poll.
// - Status byte layout: 7 operation_summary_bit, 6 summary, 5 event, 4 message, 3 quest, 2 error.
// - Mask query returns the current mask, 0 to 191 with bit 6 clear.
// - Status query returns byte with master summary, clears nothing.
// - Serial poll returns byte with request flag in bit 6, then clears it.
// - Armed trigger applies trigger levels and clears waiting-for-trigger flag.
// - Continuous initiation rearms after each trigger, sets waiting flag again.
// - Trigger and group execute act only when addressed as listener.
// - Wait-to-continue holds later commands until earlier ones and settling finish.
// - Self-test runs all subtests; returns 0 or a bit per failing subtest.
// - Status bit 5 is OR of enabled standard event bits.
`timescale 1ns/1ps
`include "icc_cfg.svh"
module icc_common_cmd #(
	parameter int LVL_W = `ICC_LVL_W,
	parameter int SETTLE_CYC = `ICC_SETTLE_CYC,
	parameter int TST_N = `ICC_TST_N,
	parameter logic [7:0] MEM_STEPS = 8'h63,
	parameter logic [7:0] LIST_STEPS = 8'hFF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Command strobe from parser
	input wire logic cmd_valid,
	input wire icc_pkg::icc_cmd_t cmd_code,
	input wire logic [7:0] cmd_arg,
	output logic cmd_ready,
	// Bus addressing state, from pins
	input wire logic listen_addr,
	// Present trigger settings
	input wire logic [LVL_W-1:0] trigger_voltage_level,
	input wire logic [LVL_W-1:0] trigger_current_level,
	input wire logic [`ICC_MODE_W-1:0] triggered_function_mode,
	input wire logic continuous_initiation,
	input wire logic arm_req,
	// Status sources
	input wire logic operation_summary_bit,
	input wire logic message_available_bit,
	input wire logic questionable_summary_bit,
	input wire logic error_queue_nonempty_bit,
	input wire logic [7:0] std_event_status,
	input wire logic [7:0] std_event_enable,
	// Output stage busy and self-test results
	input wire logic output_busy,
	input wire logic [TST_N-1:0] subtest_fail,
	input wire logic fault_set,
	// Query reply
	output logic reply_valid,
	output logic [7:0] reply_data,
	// Output channel
	output logic output_on,
	output logic [LVL_W-1:0] out_voltage,
	output logic [LVL_W-1:0] out_current,
	output logic [`ICC_MODE_W-1:0] out_mode,
	output logic mode_current,
	output logic range_auto,
	output logic fault_latched,
	output logic waiting_for_trigger_flag,
	output logic [7:0] service_request_mask,
	output logic srq_n
);
	localparam int DW = 2 * LVL_W + `ICC_MODE_W;
	localparam int SC_W = $clog2(SETTLE_CYC + 1);

	icc_pkg::icc_state_t state_r;
	logic [DW-1:0] mem_rd;
	logic [DW-1:0] stage_r;
	logic stage_full_r;
	logic mem_wr;
	logic [`ICC_SLOT_W-1:0] slot_idx;
	logic slot_ok;
	logic [SC_W-1:0] settle_r;
	logic [1:0] listen_s_r;
	logic [1:0] busy_s_r;
	logic [TST_N-1:0] tst_s0_r;
	logic [TST_N-1:0] tst_s1_r;
	logic [1:0] opt_idx_r;
	logic rqs_r;
	logic mss_r;
	logic is_poll;
	logic [7:0] stb_raw;
	logic master_summary_bit;
	logic take;
	logic is_trg;
	logic sre_wr;
	logic [7:0] opt_byte;

	// Elaboration checks: refuse settings the logic cannot serve
	if (SETTLE_CYC < 1) begin
		$error("icc_common_cmd: settle count below one");
	end
	if (TST_N < 1 || TST_N > 8) begin
		$error("icc_common_cmd: self-test width must be 1 to 8");
	end
	if (LVL_W < 1) begin
		$error("icc_common_cmd: level width below one");
	end
	if (`ICC_SLOTS > (1 << `ICC_SLOT_W)) begin
		$error("icc_common_cmd: slot count exceeds slot index range");
	end

	// Pins from outside the clock domain pass two flops first
	always_ff @(posedge ref_clk) begin
		listen_s_r <= {listen_s_r[0], listen_addr};
		busy_s_r <= {busy_s_r[0], output_busy};
		tst_s0_r <= subtest_fail;
		tst_s1_r <= tst_s0_r;
	end

	assign take = cmd_valid && cmd_ready;
	assign slot_ok = (cmd_arg >= 8'h01) && (cmd_arg <= 8'(`ICC_SLOTS));
	assign slot_idx = `ICC_SLOT_W'(cmd_arg - 8'h01);
	assign mem_wr = take && cmd_code == icc_pkg::ICC_CMD_SAV && slot_ok;
	assign is_trg = take && (cmd_code == icc_pkg::ICC_CMD_TRG || cmd_code == icc_pkg::ICC_CMD_GET)
		&& listen_s_r[1];
	assign sre_wr = take && cmd_code == icc_pkg::ICC_CMD_SRE;
	assign is_poll = take && cmd_code == icc_pkg::ICC_CMD_SPOLL;

	// Save writes the present trigger settings; recall reads them back
	icc_setup_mem #(
		.DEPTH(`ICC_SLOTS),
		.AW(`ICC_SLOT_W),
		.DW(DW)
	) u_mem (
		.ref_clk(ref_clk),
		.wr_en(mem_wr),
		.wr_addr(slot_idx),
		.wr_data({trigger_voltage_level, trigger_current_level, triggered_function_mode}),
		.rd_addr(slot_idx),
		.rd_data(mem_rd)
	);

	// Status byte assembly; unused bits forced low
	always_comb begin
		stb_raw = 8'h00;
		stb_raw[`ICC_STB_OPERATION_SUMMARY_BIT] = operation_summary_bit;
		stb_raw[`ICC_STB_ESB] = |(std_event_status & std_event_enable);
		stb_raw[`ICC_STB_MAV] = message_available_bit;
		stb_raw[`ICC_STB_QUESTIONABLE_SUMMARY_BIT] = questionable_summary_bit;
		stb_raw[`ICC_STB_ERRQ] = error_queue_nonempty_bit;
	end
	// Summary is combinational so it tracks causes; reading never clears it
	assign master_summary_bit = |(stb_raw & service_request_mask);

	// Options reply: one byte per capability token
	always_comb begin
		unique case (opt_idx_r)
			2'd0: opt_byte = 8'h01;
			2'd1: opt_byte = 8'h01;
			2'd2: opt_byte = MEM_STEPS;
			2'd3: opt_byte = LIST_STEPS;
		endcase
	end

	// Command sequencer; wait-to-continue stalls the strobe
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= icc_pkg::ICC_ST_IDLE;
			cmd_ready <= 1'b0;
			opt_idx_r <= 2'd0;
			settle_r <= '0;
		end else begin
			unique case (state_r)
				icc_pkg::ICC_ST_IDLE: begin
					cmd_ready <= 1'b1;
					if (take) begin
						cmd_ready <= 1'b0;
						unique case (cmd_code)
							icc_pkg::ICC_CMD_RCL: state_r <= slot_ok ? icc_pkg::ICC_ST_RCL : icc_pkg::ICC_ST_RD;
							icc_pkg::ICC_CMD_TST: state_r <= icc_pkg::ICC_ST_TST;
							icc_pkg::ICC_CMD_OPT: begin
								state_r <= icc_pkg::ICC_ST_OPT;
								opt_idx_r <= 2'd0;
							end
							icc_pkg::ICC_CMD_WAI: begin
								state_r <= icc_pkg::ICC_ST_WAIT;
								settle_r <= SC_W'(SETTLE_CYC);
							end
							default: state_r <= icc_pkg::ICC_ST_RD;
						endcase
					end
				end
				icc_pkg::ICC_ST_OPT: begin
					opt_idx_r <= opt_idx_r + 2'd1;
					if (opt_idx_r == 2'd3) begin
						state_r <= icc_pkg::ICC_ST_RD;
					end
				end
				icc_pkg::ICC_ST_WAIT: begin
					// Restart settling whenever the output stage reports busy
					if (busy_s_r[1]) begin
						settle_r <= SC_W'(SETTLE_CYC);
					end else if (settle_r != '0) begin
						settle_r <= settle_r - SC_W'(1);
					end else begin
						state_r <= icc_pkg::ICC_ST_RD;
					end
				end
				default: state_r <= icc_pkg::ICC_ST_IDLE;
			endcase
		end
	end

	// Query replies
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reply_valid <= 1'b0;
			reply_data <= 8'h00;
		end else begin
			reply_valid <= 1'b0;
			if (state_r == icc_pkg::ICC_ST_OPT) begin
				reply_valid <= 1'b1;
				reply_data <= opt_byte;
			end else if (state_r == icc_pkg::ICC_ST_TST) begin
				reply_valid <= 1'b1;
				// All subtests sampled together, so one failure hides none
				reply_data <= 8'(tst_s1_r);
			end else if (take) begin
				unique case (cmd_code)
					icc_pkg::ICC_CMD_SREQ: begin
						reply_valid <= 1'b1;
						reply_data <= service_request_mask;
					end
					icc_pkg::ICC_CMD_STBQ: begin
						reply_valid <= 1'b1;
						reply_data <= stb_raw | {1'b0, master_summary_bit, 6'h00};
					end
					icc_pkg::ICC_CMD_SPOLL: begin
						reply_valid <= 1'b1;
						reply_data <= stb_raw | {1'b0, rqs_r, 6'h00};
					end
					default: reply_valid <= 1'b0;
				endcase
			end
		end
	end

	// Summary history, so a standing reason does not re-raise a polled request
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mss_r <= 1'b0;
		end else begin
			mss_r <= master_summary_bit;
		end
	end

	// Request flag: raised on a new reason, cleared by serial poll; a new rise wins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rqs_r <= 1'b0;
			srq_n <= 1'b1;
		end else begin
			if (master_summary_bit && !mss_r) begin
				rqs_r <= 1'b1;
			end else if (is_poll) begin
				rqs_r <= 1'b0;
			end
			srq_n <= ~rqs_r;
		end
	end

	// Service request mask; bit 6 forced to zero on every write
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			service_request_mask <= `ICC_SRE_RST;
		end else if (sre_wr) begin
			service_request_mask <= cmd_arg & `ICC_SRE_WMASK;
		end
	end

	// Trigger stage: first recall fills it, second moves it to output
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stage_r <= '0;
			stage_full_r <= 1'b0;
		end else if (state_r == icc_pkg::ICC_ST_RCL && !stage_full_r) begin
			stage_r <= mem_rd;
			stage_full_r <= 1'b1;
		end else if (state_r == icc_pkg::ICC_ST_RCL) begin
			stage_full_r <= 1'b0;
		end else if (take && cmd_code == icc_pkg::ICC_CMD_RST) begin
			stage_full_r <= 1'b0;
		end
	end

	// Output channel, reset command and trigger
	always_ff @(posedge ref_clk) begin
		if (rst || (take && cmd_code == icc_pkg::ICC_CMD_RST)) begin
			output_on <= 1'b0;
			out_voltage <= '0;
			out_current <= '0;
			out_mode <= '0;
			mode_current <= 1'b0;
			range_auto <= 1'b1;
		end else if (state_r == icc_pkg::ICC_ST_RCL && stage_full_r) begin
			{out_voltage, out_current, out_mode} <= stage_r;
		end else if (is_trg && waiting_for_trigger_flag) begin
			out_voltage <= trigger_voltage_level;
			out_current <= trigger_current_level;
			out_mode <= triggered_function_mode;
		end else if (take && cmd_code == icc_pkg::ICC_CMD_NONE && cmd_arg == 8'h01) begin
			// Output-on arrives from the parser as a no-op code with argument one
			output_on <= 1'b1;
		end
	end

	// Fault latch cleared only by reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fault_latched <= 1'b0;
		end else if (fault_set) begin
			fault_latched <= 1'b1;
		end else if (take && cmd_code == icc_pkg::ICC_CMD_RST) begin
			fault_latched <= 1'b0;
		end
	end

	// Arming flag
	always_ff @(posedge ref_clk) begin
		if (rst || (take && cmd_code == icc_pkg::ICC_CMD_RST)) begin
			waiting_for_trigger_flag <= 1'b0;
		end else if (is_trg && waiting_for_trigger_flag) begin
			waiting_for_trigger_flag <= continuous_initiation;
		end else if (arm_req) begin
			waiting_for_trigger_flag <= 1'b1;
		end
	end
endmodule

// ==== verilog/icc_setup_mem.sv ====
// Setup memory for the saved trigger settings, registered read
`timescale 1ns/1ps
module icc_setup_mem #(
	parameter int DEPTH = 99,
	parameter int AW = 7,
	parameter int DW = 34
) (
	// Clock
	input wire logic ref_clk,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	// Read port
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [0:DEPTH-1];

	// Elaboration check: every slot must be addressable
	if (DEPTH > (1 << AW)) begin
		$error("icc_setup_mem: depth exceeds address range");
	end

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule
